//--- inc/acr_pkg.sv
package acr_pkg;
    // Register byte addresses (printed offsets are not all multiples of four: index times four)
    localparam logic [7:0] ACR_IDX_PWM_GAIN   = 8'h06;
    localparam logic [7:0] ACR_IDX_SLEEP_SLOT = 8'h13;
    localparam logic [7:0] ACR_IDX_ANALOG     = 8'h14;
    localparam logic [7:0] ACR_IDX_STATUS     = 8'h20;
    localparam logic [9:0] ACR_ADDR_PWM_GAIN   = {ACR_IDX_PWM_GAIN, 2'b00};
    localparam logic [9:0] ACR_ADDR_SLEEP_SLOT = {ACR_IDX_SLEEP_SLOT, 2'b00};
    localparam logic [9:0] ACR_ADDR_ANALOG     = {ACR_IDX_ANALOG, 2'b00};
    localparam logic [9:0] ACR_ADDR_STATUS     = {ACR_IDX_STATUS, 2'b00};
    localparam int ACR_ADDR_W = 10;

    // Reset values
    localparam logic [7:0] ACR_RST_PWM_GAIN   = 8'h50;
    localparam logic [7:0] ACR_RST_SLEEP_SLOT = 8'h00;
    localparam logic [7:0] ACR_RST_ANALOG     = 8'h02;

    // Field positions
    localparam int ACR_PWM_LO    = 4;
    localparam int ACR_GAIN_LO   = 2;
    localparam int ACR_SLEEP_LO  = 3;
    localparam int ACR_SLOT_BIT  = 2;
    localparam int ACR_CLKSRC_BIT = 1;
    localparam int ACR_VOL0_BIT  = 0;
    localparam int ACR_PULLUP_BIT = 3;
    localparam int ACR_VREG_BIT  = 2;
    localparam int ACR_RSV1_BIT  = 1;
    localparam int ACR_TRIM_BIT  = 0;

    // Auto sleep idle runs, in frame clocks
    localparam logic [1:0] ACR_SLEEP_OFF = 2'h0;
    localparam logic [1:0] ACR_SLEEP_1K  = 2'h1;
    localparam logic [1:0] ACR_SLEEP_64K = 2'h2;
    localparam int ACR_FRAMES_1K   = 1024;
    localparam int ACR_FRAMES_64K  = 64 * 1024;
    localparam int ACR_FRAMES_256K = 256 * 1024;
    localparam int ACR_IDLE_W      = 19;

    // Slot widths in bits
    localparam int ACR_SLOT_LONG  = 32;
    localparam int ACR_SLOT_SHORT = 16;
    localparam int ACR_BIT_CNT_W  = 6;
endpackage

//--- hw/acr_link_rx.sv
`timescale 1ns/100ps
// Link-side receiver: counts idle frames on the bit clock and reports sleep
module acr_link_rx
    import acr_pkg::*;
#(
    parameter int FRAMES_1K   = acr_pkg::ACR_FRAMES_1K,
    parameter int FRAMES_64K  = acr_pkg::ACR_FRAMES_64K,
    parameter int FRAMES_256K = acr_pkg::ACR_FRAMES_256K
) (
    // Link clock and reset
    input  wire logic       link_bclk,
    input  wire logic       hresetn,
    // Serial audio
    input  wire logic       link_frame,
    input  wire logic       link_data,
    // Configuration, quasi-static, synchronised here
    input  wire logic [1:0] sleep_sel,
    input  wire logic       slot_width_select,
    // Status toward the bus domain
    output logic            sleep_active,
    output logic            frame_toggle
);
    typedef struct packed {
        logic [1:0]              sel_s1;
        logic [1:0]              sel_s2;
        logic                    slot_s1;
        logic                    slot_s2;
        logic                    frame_d;
        logic [ACR_BIT_CNT_W-1:0] bit_cnt;
        logic                    nonzero;
        logic [ACR_IDLE_W-1:0]   idle_cnt;
        logic                    sleep;
        logic                    tog;
    } acr_rx_t;

    acr_rx_t st;
    acr_rx_t next_st;
    logic [ACR_IDLE_W-1:0] limit;
    logic                  frame_start;
    logic                  in_slot;

    // Idle limit from the selected sleep code
    function automatic logic [ACR_IDLE_W-1:0] idle_limit(input logic [1:0] sel);
        unique case (sel)
            ACR_SLEEP_OFF: idle_limit = '0;
            ACR_SLEEP_1K:  idle_limit = ACR_IDLE_W'(FRAMES_1K);
            ACR_SLEEP_64K: idle_limit = ACR_IDLE_W'(FRAMES_64K);
            default:       idle_limit = ACR_IDLE_W'(FRAMES_256K);
        endcase
    endfunction

    // Frame rising edge starts a frame; only the first slot is our channel
    always_comb begin
        next_st     = st;
        limit       = idle_limit(st.sel_s2);
        frame_start = link_frame & ~st.frame_d;
        in_slot     = (st.bit_cnt < (st.slot_s2 ? ACR_BIT_CNT_W'(ACR_SLOT_SHORT)
                                                : ACR_BIT_CNT_W'(ACR_SLOT_LONG)));
        next_st.sel_s1  = sleep_sel;
        next_st.sel_s2  = st.sel_s1;
        next_st.slot_s1 = slot_width_select;
        next_st.slot_s2 = st.slot_s1;
        next_st.frame_d = link_frame;
        if (frame_start) begin
            next_st.tog     = ~st.tog;
            next_st.bit_cnt = ACR_BIT_CNT_W'(1);
            next_st.nonzero = link_data;
            // Evaluate the finished frame's sample
            if (st.nonzero) begin
                next_st.idle_cnt = '0;
                next_st.sleep    = 1'b0;
            end else if (st.idle_cnt != {ACR_IDLE_W{1'b1}}) begin
                next_st.idle_cnt = st.idle_cnt + ACR_IDLE_W'(1);
            end
            if (!st.nonzero && limit != '0 && st.idle_cnt + ACR_IDLE_W'(1) >= limit) begin
                next_st.sleep = 1'b1;
            end
            if (limit == '0) begin
                next_st.sleep = 1'b0;
            end
        end else begin
            if (in_slot) begin
                next_st.nonzero = st.nonzero | link_data;
                next_st.bit_cnt = st.bit_cnt + ACR_BIT_CNT_W'(1);
            end
        end
    end

    // Link-domain state; reset is constant only
    always_ff @(posedge link_bclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sleep_active = st.sleep;
    assign frame_toggle = st.tog;
endmodule

//--- hw/acr_ctrl.sv
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
// Function
// - Sleep after selected idle frame count
// - Slot width 16 when set, else 32
// - Clock source bit picks pin or bit clock
// - Bit 0 is volume least significant bit
// - Bit 3 enables fault pin pull-up
// - Bit 2 selects reduced regulator level
// - Bit 0 reduces static analog current
// - PWM rate bits 6-4, reset 101
// - Analog gain bits 3-2, host writable
// - Control clock up to 400 kHz
// - Frame rates single or double speed
module acr_ctrl
    import acr_pkg::*;
#(
    parameter int FRAMES_1K   = acr_pkg::ACR_FRAMES_1K,
    parameter int FRAMES_64K  = acr_pkg::ACR_FRAMES_64K,
    parameter int FRAMES_256K = acr_pkg::ACR_FRAMES_256K
) (
    // Bus clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial audio link
    input  wire logic        link_bclk,
    input  wire logic        link_frame,
    input  wire logic        link_data,
    // Master clock pin
    input  wire logic        mclk_pin,
    // Controls toward the analog section
    output logic             power_stage_enable,
    output logic             slot_width_select,
    output logic             mclk_from_pin,
    output logic             volume_level_lsb,
    output logic             fault_pin_pullup_enable,
    output logic             regulator_level_select,
    output logic             analog_current_trim,
    output logic [2:0]       pwm_rate,
    output logic [1:0]       analog_gain
);
    typedef struct packed {
        logic                  wr_pend;
        logic [ACR_ADDR_W-1:0] wr_addr;
        logic [31:0]           rdata;
        logic [7:0]            pwm_gain;
        logic [7:0]            sleep_slot;
        logic [7:0]            analog;
        logic                  sleep_s1;
        logic                  sleep_s2;
        logic                  tog_s1;
        logic                  tog_s2;
        logic                  tog_d;
        logic                  frame_seen;
        logic                  mclk_s1;
        logic                  mclk_s2;
    } acr_state_t;

    acr_state_t st;
    acr_state_t next_st;
    logic       sleep_link;
    logic       tog_link;
    logic       addr_ok;
    logic [7:0] wbyte;

    // Read mux shared by the address phase
    function automatic logic [31:0] reg_read(input logic [ACR_ADDR_W-1:0] a, input acr_state_t s);
        unique case (a)
            ACR_ADDR_PWM_GAIN:   reg_read = {24'h0, s.pwm_gain};
            ACR_ADDR_SLEEP_SLOT: reg_read = {24'h0, s.sleep_slot};
            ACR_ADDR_ANALOG:     reg_read = {24'h0, s.analog};
            ACR_ADDR_STATUS:     reg_read = {29'h0, s.mclk_s2, s.frame_seen, s.sleep_s2};
            default:             reg_read = 32'h0;
        endcase
    endfunction

    // Link-side idle detector on its own clock
    acr_link_rx #(
        .FRAMES_1K   (FRAMES_1K),
        .FRAMES_64K  (FRAMES_64K),
        .FRAMES_256K (FRAMES_256K)
    ) u_rx (
        .link_bclk         (link_bclk),
        .hresetn           (hresetn),
        .link_frame        (link_frame),
        .link_data         (link_data),
        .sleep_sel         (st.sleep_slot[ACR_SLEEP_LO+1:ACR_SLEEP_LO]),
        .slot_width_select (st.sleep_slot[ACR_SLOT_BIT]),
        .sleep_active      (sleep_link),
        .frame_toggle      (tog_link)
    );

    // Bus slave: zero wait states, write stored at data phase, read data registered
    always_comb begin
        next_st  = st;
        addr_ok  = hsel & hready & htrans[1];
        wbyte    = hwdata[7:0];
        // Crossings: two flops each, second flop read; the toggle also reads a third flop, tog_d, for edge detection
        next_st.sleep_s1 = sleep_link;
        next_st.sleep_s2 = st.sleep_s1;
        next_st.tog_s1   = tog_link;
        next_st.tog_s2   = st.tog_s1;
        next_st.tog_d    = st.tog_s2;
        next_st.mclk_s1  = mclk_pin;
        next_st.mclk_s2  = st.mclk_s1;
        if (st.tog_s2 != st.tog_d) begin
            next_st.frame_seen = 1'b1;
        end
        if (st.wr_pend) begin
            unique case (st.wr_addr)
                ACR_ADDR_PWM_GAIN:   next_st.pwm_gain   = wbyte;
                ACR_ADDR_SLEEP_SLOT: next_st.sleep_slot = wbyte;
                ACR_ADDR_ANALOG:     next_st.analog     = wbyte;
                ACR_ADDR_STATUS: begin
                    // Writing the status word clears frame seen; a new frame wins
                    if (st.tog_s2 == st.tog_d) begin
                        next_st.frame_seen = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        next_st.wr_pend = addr_ok & hwrite;
        next_st.wr_addr = haddr[ACR_ADDR_W-1:0];
        if (addr_ok && !hwrite) begin
            next_st.rdata = reg_read(haddr[ACR_ADDR_W-1:0], st);
        end
    end

    // Bus-domain state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st            <= '0;
            st.pwm_gain   <= ACR_RST_PWM_GAIN;
            st.sleep_slot <= ACR_RST_SLEEP_SLOT;
            st.analog     <= ACR_RST_ANALOG;
        end else begin
            st <= next_st;
        end
    end

    // Always ready, always OKAY; no wait states, so a slow control clock is never a limit
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.rdata;

    // Field outputs
    assign power_stage_enable      = ~st.sleep_s2;
    assign slot_width_select       = st.sleep_slot[ACR_SLOT_BIT];
    assign mclk_from_pin           = st.sleep_slot[ACR_CLKSRC_BIT];
    assign volume_level_lsb        = st.sleep_slot[ACR_VOL0_BIT];
    assign fault_pin_pullup_enable = st.analog[ACR_PULLUP_BIT];
    assign regulator_level_select  = st.analog[ACR_VREG_BIT];
    assign analog_current_trim     = st.analog[ACR_TRIM_BIT];
    assign pwm_rate                = st.pwm_gain[ACR_PWM_LO+2:ACR_PWM_LO];
    assign analog_gain             = st.pwm_gain[ACR_GAIN_LO+1:ACR_GAIN_LO];
endmodule

//--- dv/acr_ctrl_sva.sv
`timescale 1ns/100ps
// Port-level checks of the control register block
module acr_ctrl_sva
    import acr_pkg::*;
#(
    parameter int FRAMES_1K   = 4,
    parameter int FRAMES_64K  = 8,
    parameter int FRAMES_256K = 16
) (
    // Bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Controls
    input wire logic        power_stage_enable,
    input wire logic        slot_width_select,
    input wire logic        mclk_from_pin,
    input wire logic        volume_level_lsb,
    input wire logic        fault_pin_pullup_enable,
    input wire logic        regulator_level_select,
    input wire logic        analog_current_trim,
    input wire logic [2:0]  pwm_rate,
    input wire logic [1:0]  analog_gain
);
    logic tk, wa, wp, wd, ra, ru;
    // Decoded address phases taken on the bus
    assign tk = hsel & hready & htrans[1];
    assign wa = tk & hwrite & (haddr[9:0] == ACR_ADDR_ANALOG);
    assign wp = tk & hwrite & (haddr[9:0] == ACR_ADDR_PWM_GAIN);
    assign wd = tk & hwrite & (haddr[9:0] == ACR_ADDR_SLEEP_SLOT);
    assign ra = tk & !hwrite & (haddr[9:0] == ACR_ADDR_ANALOG);
    assign ru = tk & !hwrite & (haddr[9:0] == 10'h3fc);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    bus_okay_a: assert property (tk |=> hreadyout && !hresp) else $error("bus answer not ready or not okay");
    pwm_reset_a: assert property ($rose(hresetn) |-> pwm_rate == 3'b101 && analog_gain == 2'b00)
        else $error("pwm field reset value wrong");
    ctl_reset_a: assert property ($rose(hresetn) |-> !fault_pin_pullup_enable && !regulator_level_select
        && !analog_current_trim && !slot_width_select && !mclk_from_pin && power_stage_enable) else $error("reset state");
    ana_write_a: assert property (wa ##1 1 |=> {fault_pin_pullup_enable, regulator_level_select}
        == $past(hwdata[3:2]) && analog_current_trim == $past(hwdata[0])) else $error("analog write lost");
    pwm_write_a: assert property (wp ##1 1 |=> {pwm_rate, analog_gain} == $past(hwdata[6:2]))
        else $error("pwm gain write lost");
    dig_write_a: assert property (wd ##1 1 |=> {slot_width_select, mclk_from_pin, volume_level_lsb}
        == $past(hwdata[2:0])) else $error("digital write lost");
    pwm_hold_a: assert property (!$past(wp, 2) |-> $stable(pwm_rate) && $stable(analog_gain))
        else $error("pwm field changed without write");
    ana_read_a: assert property (ra |=> hrdata[3:2] == $past({fault_pin_pullup_enable, regulator_level_select})
        && hrdata[0] == $past(analog_current_trim)) else $error("analog readback wrong");
    unmap_read_a: assert property (ru |=> hrdata == 32'h0) else $error("unmapped read not zero");

    cover property (wa);
    cover property ($fell(power_stage_enable));
    cover property ($rose(power_stage_enable));
endmodule

bind acr_ctrl acr_ctrl_sva #(.FRAMES_1K(FRAMES_1K), .FRAMES_64K(FRAMES_64K), .FRAMES_256K(FRAMES_256K)) sva_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .power_stage_enable(power_stage_enable), .slot_width_select(slot_width_select),
    .mclk_from_pin(mclk_from_pin), .volume_level_lsb(volume_level_lsb),
    .fault_pin_pullup_enable(fault_pin_pullup_enable), .regulator_level_select(regulator_level_select),
    .analog_current_trim(analog_current_trim), .pwm_rate(pwm_rate), .analog_gain(analog_gain));

//--- dv/acr_audio_src.sv
`timescale 1ns/100ps
// Host audio source; its bit clock stands still between runs of frames
module acr_audio_src (
    // Serial audio toward the block
    output logic link_bclk,
    output logic link_frame,
    output logic link_data
);
    // A few edges at start so link logic sees the reset
    initial begin
        link_frame = 1'b0;
        link_data = 1'b0;
        link_bclk = 1'b0;
        #3;
        repeat (3) begin
            #6 link_bclk = 1'b1;
            #6 link_bclk = 1'b0;
        end
    end
    // Frames of 32 bits, msb first, data changed while the clock is low
    task automatic run(input int n, input logic [31:0] word);
        for (int f = 0; f < n; f++) begin
            for (int b = 0; b < 32; b++) begin
                link_frame = (b < 16);
                link_data = word[31 - b];
                #6 link_bclk = 1'b1;
                #6 link_bclk = 1'b0;
            end
        end
        link_frame = 1'b0;
        link_data = ~link_data; // Released line must not keep a stale value
    endtask
endmodule

//--- dv/tb_amp_control_register_fields.sv
`timescale 1ns/100ps
// Self-checking bench for the control register block
module tb_amp_control_register_fields;
    import acr_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mclk_pin, pse;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans, gain;
    logic [2:0] hsize, pwm;
    logic link_bclk, link_frame, link_data, sws, mfp, vol, fpe, rls, act;
    int miscompares, n_tests, cyc;
    logic [9:0] ta [6] = '{ACR_ADDR_ANALOG, ACR_ADDR_ANALOG, ACR_ADDR_PWM_GAIN, ACR_ADDR_PWM_GAIN,
                           ACR_ADDR_SLEEP_SLOT, ACR_ADDR_SLEEP_SLOT};
    logic [7:0] td [6] = '{8'h0b, 8'h06, 8'h3c, 8'h48, 8'h05, 8'h02};
    logic [10:0] te [6] = '{11'b101_00_101_000, 11'b101_00_010_000, 11'b011_11_010_000, 11'b100_10_010_000,
                            11'b100_10_010_101, 11'b100_10_010_010};

    acr_ctrl #(.FRAMES_1K(4), .FRAMES_64K(8), .FRAMES_256K(16)) acr_ctrl_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link_bclk(link_bclk), .link_frame(link_frame), .link_data(link_data),
        .mclk_pin(mclk_pin), .power_stage_enable(pse), .slot_width_select(sws), .mclk_from_pin(mfp),
        .volume_level_lsb(vol), .fault_pin_pullup_enable(fpe), .regulator_level_select(rls),
        .analog_current_trim(act), .pwm_rate(pwm), .analog_gain(gain));
    acr_audio_src acr_audio_src_i (.link_bclk(link_bclk), .link_frame(link_frame), .link_data(link_data));

    // Bus clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            close_out;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One single transfer; the wait for the edge leaves an idle cycle between transfers
    task automatic ahb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Stream frames, then let the sleep state cross into the bus domain
    task automatic frames(input int n, input logic [31:0] w, input logic e);
        acr_audio_src_i.run(n, w);
        repeat (12) @(negedge hclk);
        chk({31'h0, pse}, {31'h0, e});
    endtask
    task automatic t_reset;
        ahb(0, ACR_ADDR_PWM_GAIN, 0);
        chk(r, 32'h50);
        ahb(0, ACR_ADDR_SLEEP_SLOT, 0);
        chk(r, 32'h0);
        ahb(0, ACR_ADDR_ANALOG, 0);
        chk(r, 32'h2);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 6; i++) begin
            ahb(1, ta[i], {24'h0, td[i]});
            @(negedge hclk);
            chk({21'h0, pwm, gain, fpe, rls, act, sws, mfp, vol}, {21'h0, te[i]});
            ahb(0, ta[i], 0);
            chk(r, {24'h0, td[i]});
        end
        ahb(1, 10'h3fc, 32'hff);
        ahb(0, 10'h3fc, 0);
        chk(r, 32'h0);
    endtask
    task automatic t_sleep;
        mclk_pin <= 1'b1;
        for (int s = 1; s < 4; s++) begin
            ahb(1, ACR_ADDR_SLEEP_SLOT, s << 3);
            frames(2, 32'h1, 1'b1);
            frames((2 << s) - 1, 32'h0, 1'b1);
            frames(2, 32'h0, 1'b0);
        end
        ahb(1, ACR_ADDR_SLEEP_SLOT, 32'h0c);
        frames(2, 32'h8000_0000, 1'b1);
        frames(6, 32'h1, 1'b0);
        ahb(1, ACR_ADDR_SLEEP_SLOT, 32'h00);
        frames(20, 32'h0, 1'b1);
        ahb(0, ACR_ADDR_STATUS, 0);
        chk(r, 32'h6);
        ahb(1, ACR_ADDR_STATUS, 0);
        ahb(0, ACR_ADDR_STATUS, 0);
        chk(r, 32'h4);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        mclk_pin = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        miscompares = 0;
        n_tests = 0;
        cyc = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_regs;
        t_sleep;
        close_out;
    end
endmodule
